// File: dpmsc_ctrl.sv
// Purpose: operating mode, state and reference choice of one loop
// Assumes: inputs synchronous to pclk; monitor flags high on failure
// Notes:   register reads answer with one wait state
//
// Notes on behaviour
// - five modes; only automatic and forced reference can lock
// - locking modes sit in acquiring, locked or holdover
// - forced mode holds over on chosen reference loss if retention mask set, others ignored
// - holdover output uses frequency captured while locked
// - forced holdover ignores references and both masks
// - freerun uses master clock only, no lock, switch or holdover
// - forced mode locks to host reference, never switches
// - forced mode with retention mask set holds over on failure
// - forced mode with retention mask clear keeps locking to it
// - automatic with switch mask picks by availability and priority
// - automatic, retention mask only: failure gives holdover
// - automatic, no masks: keep locking to failed reference
// - oscillator mode free runs; each offset write retunes output
// - lock, holdover and tracking flags together encode the loop state
// - bandwidth select offers 14, 29, 61, 130, 380, 470 Hz
// - damping gain programmable, default 5
// - lock within two seconds at 14 Hz or more, no slope limit
// - lock phase threshold and lock period programmable
// - reference switch passes through holdover
// - priority 0..10, lower wins, 15 excludes, ties to lower index
// - switch mask only automatic; retention mask automatic and forced
`timescale 1ns/100ps
module dpmsc_ctrl #(
  parameter int NREF        = 11,                       // reference count
  parameter int TICK_CYCLES = dpmsc_pkg::TICK_CYCLES    // cycles per ms
) (
  input  wire logic                               pclk,                  // bus clock
  input  wire logic                               presetn,               // async reset
  input  wire logic [dpmsc_pkg::ADDR_W-1:0]       paddr,                 // byte address
  input  wire logic                               psel,                  // select
  input  wire logic                               penable,               // access phase
  input  wire logic                               pwrite,                // write
  input  wire logic [dpmsc_pkg::DATA_W-1:0]       pwdata,                // write data
  output logic      [dpmsc_pkg::DATA_W-1:0]       prdata,                // read data
  output logic                                    pready,                // ready
  output logic                                    pslverr,               // error
  input  wire logic [NREF-1:0][dpmsc_pkg::MON_W-1:0] ref_monitor_fail,   // monitor fails
  input  wire logic [15:0]                        phase_error_mag,       // phase error
  input  wire logic [31:0]                        loop_freq_word,        // loop estimate
  output logic                                    lock_achieved_flag,    // high when locked
  output logic                                    retention_state_flag,  // holdover
  output logic      [dpmsc_pkg::REF_IDX_W-1:0]    selected_reference,    // chosen ref
  output logic                                    dco_from_reference,    // tracking ref
  output logic      [31:0]                        dco_freq_word,         // oscillator word
  output logic      [2:0]                         loop_bandwidth_select, // bandwidth code
  output logic      [3:0]                         damping_gain,          // damping
  output logic                                    fast_lock_enable,      // fast lock
  output logic                                    nco_update             // offset pulse
);
  import dpmsc_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  typedef struct packed {
    logic                         pready;
    logic                         pslverr;
    logic [DATA_W-1:0]            prdata;
    dpmsc_mode_t                  mode;
    logic [REF_IDX_W-1:0]         forced_ref;
    logic [MON_W-1:0]             sw_mask;
    logic [MON_W-1:0]             ret_mask;
    logic [2:0]                   bw;
    logic [3:0]                   damp;
    logic [15:0]                  lock_phase;
    logic [7:0]                   lock_period;
    logic                         fast_lock;
    logic [NREF-1:0][PRIO_W-1:0]  prio;
    logic [31:0]                  offset;
    logic                         nco_upd;
    dpmsc_state_t                 st;
    logic [REF_IDX_W-1:0]         cur_ref;
    logic [31:0]                  held;
    logic [31:0]                  dco;
    logic                         dco_ext;
    logic                         lock_flag;
    logic                         ret_flag;
    logic [TW-1:0]                tick_cnt;
    logic                         tick;
    logic [7:0]                   ms_cnt;
  } dpmsc_regs_t;

  dpmsc_regs_t r;
  dpmsc_regs_t next_r;

  // ==========================================================
  // decode helpers
  function automatic logic ref_failed(
    input logic [NREF-1:0][MON_W-1:0] fails,
    input logic [REF_IDX_W-1:0]       idx,
    input logic [MON_W-1:0]           mask
  );
    logic res;
    res = 1'b1;
    if (32'(idx) < NREF) begin
      res = |(fails[idx] & mask);
    end
    return res;
  endfunction : ref_failed

  function automatic logic prio_usable(input logic [PRIO_W-1:0] p);
    return p <= PRIO_MAX;
  endfunction : prio_usable

  // lowest value wins; strict compare keeps the lower index on ties
  function automatic logic [REF_IDX_W:0] pick_best(
    input logic [NREF-1:0]              av,
    input logic [NREF-1:0][PRIO_W-1:0]  pr
  );
    logic                 found;
    logic [REF_IDX_W-1:0] idx;
    logic [PRIO_W-1:0]    bp;
    found = 1'b0;
    idx   = '0;
    bp    = PRIO_OFF;
    for (int i = 0; i < NREF; i++) begin
      if (av[i] && (!found || pr[i] < bp)) begin
        found = 1'b1;
        idx   = REF_IDX_W'(i);
        bp    = pr[i];
      end
    end
    return {found, idx};
  endfunction : pick_best

  // ==========================================================
  // reference availability under the switch mask
  logic [NREF-1:0] avail;

  for (genvar g = 0; g < NREF; g++) begin : g_avail
    assign avail[g] = !(|(ref_monitor_fail[g] & r.sw_mask))
                      && prio_usable(r.prio[g]);
  end

  logic [REF_IDX_W:0] best;
  logic               best_found;
  logic [REF_IDX_W-1:0] best_idx;
  logic               cur_avail;
  logic               better;
  logic               cur_ret_fail;

  assign best       = pick_best(avail, r.prio);
  assign best_found = best[REF_IDX_W];
  assign best_idx   = best[REF_IDX_W-1:0];
  assign cur_avail  = (32'(r.cur_ref) < NREF) && avail[r.cur_ref];
  assign better     = best_found && (!cur_avail || r.prio[best_idx] < r.prio[r.cur_ref]);
  assign cur_ret_fail = ref_failed(ref_monitor_fail, r.cur_ref, r.ret_mask);

  // ==========================================================
  // next state
  always_comb begin
    logic issue;
    logic commit;
    logic tracking;
    issue    = psel && penable && !r.pready;
    commit   = psel && penable && r.pready && pwrite;
    tracking = 1'b0;
    next_r   = r;
    next_r.nco_upd = 1'b0;
    next_r.pready  = issue;
    next_r.pslverr = 1'b0;

    // bus answer is loaded one cycle ahead of the completing edge
    if (issue) begin
      next_r.prdata  = '0;
      case (paddr)
        REG_CTRL: begin
          next_r.prdata[CTRL_MODE_LSB +: CTRL_MODE_W] = r.mode;
          next_r.prdata[CTRL_REF_LSB +: REF_IDX_W]    = r.forced_ref;
        end
        REG_MASK: begin
          next_r.prdata[MASK_SW_LSB +: MON_W]  = r.sw_mask;
          next_r.prdata[MASK_RET_LSB +: MON_W] = r.ret_mask;
        end
        REG_LOOP: begin
          next_r.prdata[LOOP_BW_LSB +: LOOP_BW_W]     = r.bw;
          next_r.prdata[LOOP_DAMP_LSB +: LOOP_DAMP_W] = r.damp;
        end
        REG_LOCK: begin
          next_r.prdata[LOCK_PHASE_LSB +: LOCK_PHASE_W]   = r.lock_phase;
          next_r.prdata[LOCK_PERIOD_LSB +: LOCK_PERIOD_W] = r.lock_period;
          next_r.prdata[LOCK_FAST_BIT]                    = r.fast_lock;
        end
        REG_PRIO0, REG_PRIO1: begin
          for (int i = 0; i < NREF; i++) begin
            if ((i / PRIO_PER_REG) == int'(paddr == REG_PRIO1)) begin
              next_r.prdata[(i % PRIO_PER_REG) * PRIO_W +: PRIO_W] = r.prio[i];
            end
          end
        end
        REG_OFFSET: begin
          next_r.prdata = '0; // write-only
        end
        REG_STATUS: begin
          next_r.prdata[STAT_STATE_LSB +: 2]      = r.st;
          next_r.prdata[STAT_REF_LSB +: REF_IDX_W] = r.cur_ref;
          next_r.prdata[STAT_LOCK_BIT]            = r.lock_flag;
          next_r.prdata[STAT_RET_BIT]             = r.ret_flag;
          next_r.prdata[STAT_EXT_BIT]             = r.dco_ext;
        end
        REG_HELD: begin
          next_r.prdata = r.held;
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end

    // writes land on the edge where the master sees pready high
    if (commit) begin
      case (paddr)
        REG_CTRL: begin
          next_r.mode       = dpmsc_mode_t'(pwdata[CTRL_MODE_LSB +: CTRL_MODE_W]);
          next_r.forced_ref = pwdata[CTRL_REF_LSB +: REF_IDX_W];
        end
        REG_MASK: begin
          next_r.sw_mask  = pwdata[MASK_SW_LSB +: MON_W];
          next_r.ret_mask = pwdata[MASK_RET_LSB +: MON_W];
        end
        REG_LOOP: begin
          next_r.bw   = pwdata[LOOP_BW_LSB +: LOOP_BW_W];
          next_r.damp = pwdata[LOOP_DAMP_LSB +: LOOP_DAMP_W];
        end
        REG_LOCK: begin
          next_r.lock_phase  = pwdata[LOCK_PHASE_LSB +: LOCK_PHASE_W];
          next_r.lock_period = pwdata[LOCK_PERIOD_LSB +: LOCK_PERIOD_W];
          next_r.fast_lock   = pwdata[LOCK_FAST_BIT];
        end
        REG_PRIO0, REG_PRIO1: begin
          for (int i = 0; i < NREF; i++) begin
            if ((i / PRIO_PER_REG) == int'(paddr == REG_PRIO1)) begin
              next_r.prio[i] = pwdata[(i % PRIO_PER_REG) * PRIO_W +: PRIO_W];
            end
          end
        end
        REG_OFFSET: begin
          next_r.offset  = pwdata;
          next_r.nco_upd = 1'b1;
        end
        default: begin
          next_r.offset = r.offset;
        end
      endcase
    end

    // millisecond tick for the lock period
    next_r.tick = 1'b0;
    if (r.tick_cnt == TW'(TICK_CYCLES - 1)) begin
      next_r.tick_cnt = '0;
      next_r.tick     = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 1'b1;
    end

    // mode and reference decision
    case (r.mode)
      MODE_HOLDOVER: begin
        next_r.st = ST_HOLD;
      end
      MODE_FORCED: begin
        if (r.forced_ref != r.cur_ref) begin
          next_r.cur_ref = r.forced_ref;
          next_r.st      = ST_HOLD;
        end else if (r.ret_mask != '0 && cur_ret_fail) begin
          next_r.st = ST_HOLD;
        end else if (r.st == ST_FREE || r.st == ST_HOLD) begin
          next_r.st = ST_ACQ;
        end
      end
      MODE_AUTO: begin
        if (r.sw_mask != '0) begin
          if (r.st == ST_ACQ || r.st == ST_LOCK) begin
            if (!cur_avail || better) begin
              next_r.st = ST_HOLD;
            end
          end else if (cur_avail && !better && r.st != ST_FREE) begin
            next_r.st = ST_ACQ;
          end else if (best_found) begin
            next_r.cur_ref = best_idx;
            next_r.st      = ST_ACQ;
          end else begin
            next_r.st = ST_HOLD;
          end
        end else if (r.ret_mask != '0 && cur_ret_fail) begin
          next_r.st = ST_HOLD;
        end else if (r.st == ST_FREE || r.st == ST_HOLD) begin
          next_r.st = ST_ACQ;
        end
      end
      default: begin
        next_r.st = ST_FREE;
      end
    endcase

    // lock qualification: phase under threshold for the lock period
    if (next_r.st == ST_ACQ && r.st == ST_ACQ) begin
      if (phase_error_mag <= r.lock_phase) begin
        if (r.ms_cnt >= r.lock_period) begin
          next_r.st     = ST_LOCK;
          next_r.ms_cnt = '0;
        end else if (r.tick) begin
          next_r.ms_cnt = r.ms_cnt + 1'b1;
        end
      end else begin
        next_r.ms_cnt = '0;
      end
    end else begin
      next_r.ms_cnt = '0;
    end
    // large phase error while locked returns the loop to acquiring
    if (next_r.st == ST_LOCK && r.st == ST_LOCK && phase_error_mag > r.lock_phase) begin
      next_r.st = ST_ACQ;
    end

    // holdover estimate only from locked operation
    if (r.st == ST_LOCK) begin
      next_r.held = loop_freq_word;
    end

    case (next_r.st)
      ST_ACQ, ST_LOCK: begin
        tracking = 1'b1;
        next_r.dco = loop_freq_word;
      end
      ST_HOLD: begin
        next_r.dco = (r.st == ST_LOCK) ? loop_freq_word : next_r.held;
      end
      default: begin
        next_r.dco = (r.mode == MODE_NCO) ? next_r.offset : '0;
      end
    endcase
    next_r.dco_ext   = tracking;
    next_r.lock_flag = (next_r.st == ST_LOCK);
    next_r.ret_flag  = (next_r.st == ST_HOLD);
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r             <= '0;
      r.mode        <= MODE_FREERUN;
      r.st          <= ST_FREE;
      r.sw_mask     <= MASK_RST;
      r.ret_mask    <= MASK_RST;
      r.bw          <= BW_14HZ;
      r.damp        <= DAMP_RST;
      r.lock_phase  <= LOCK_PHASE_RST;
      r.lock_period <= LOCK_PERIOD_RST;
      for (int i = 0; i < NREF; i++) begin
        r.prio[i] <= PRIO_W'(i);
      end
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign prdata                = r.prdata;
  assign pready                = r.pready;
  assign pslverr               = r.pslverr;
  assign lock_achieved_flag    = r.lock_flag;
  assign retention_state_flag  = r.ret_flag;
  assign selected_reference    = r.cur_ref;
  assign dco_from_reference    = r.dco_ext;
  assign dco_freq_word         = r.dco;
  assign loop_bandwidth_select = r.bw;
  assign damping_gain          = r.damp;
  assign fast_lock_enable      = r.fast_lock;
  assign nco_update            = r.nco_upd;

endmodule : dpmsc_ctrl

// File: dpmsc_ctrl_asserts.sv
// Purpose: port checks of the loop controller
// Assumes: one pclk domain
// Notes:   bound to every dpmsc_ctrl instance
`timescale 1ns/100ps
module dpmsc_ctrl_asserts
  import dpmsc_pkg::*;
#(
  parameter int NREF = 11
) (
  input wire logic        pclk, // clock
  input wire logic        presetn, // reset
  input wire logic [7:0]  paddr, // address
  input wire logic        psel, // select
  input wire logic        penable, // access phase
  input wire logic        pwrite, // write
  input wire logic        pready, // ready
  input wire logic        pslverr, // error
  input wire logic        lock_achieved_flag, // locked
  input wire logic        retention_state_flag, // holdover
  input wire logic [3:0]  selected_reference, // reference
  input wire logic        dco_from_reference, // tracking
  input wire logic [31:0] dco_freq_word, // output word
  input wire logic [3:0]  damping_gain, // damping
  input wire logic        nco_update // offset pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // bus answer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_off_wr;
    psel && penable && pready && pwrite && paddr == REG_OFFSET;
  endsequence
  a_ready_wait: assert property (s_setup |=> !pready ##1 pready)
    else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("long ready");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("lone error");

  // ==========================================================
  // loop state
  a_lock_track: assert property (lock_achieved_flag |-> dco_from_reference && !retention_state_flag)
    else $error("lock untracked");
  a_hold_free: assert property (retention_state_flag |-> !dco_from_reference)
    else $error("holdover tracks");
  a_hold_freq: assert property (retention_state_flag && $past(retention_state_flag) |-> $stable(dco_freq_word))
    else $error("holdover word moved");
  a_track_ref: assert property (dco_from_reference && $past(dco_from_reference) |-> $stable(selected_reference))
    else $error("reference jumped");
  a_lock_entry: assert property ($rose(lock_achieved_flag) |-> $past(dco_from_reference) && !$past(retention_state_flag))
    else $error("bad lock entry");
  a_nco_pulse: assert property (s_off_wr |=> nco_update ##1 !nco_update)
    else $error("no offset pulse");
  a_damp_reset: assert property ($rose(presetn) |-> damping_gain == DAMP_RST)
    else $error("damping reset");
endmodule : dpmsc_ctrl_asserts

bind dpmsc_ctrl dpmsc_ctrl_asserts #(.NREF(NREF)) u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .lock_achieved_flag(lock_achieved_flag), .retention_state_flag(retention_state_flag),
  .selected_reference(selected_reference), .dco_from_reference(dco_from_reference),
  .dco_freq_word(dco_freq_word), .damping_gain(damping_gain), .nco_update(nco_update));

// File: dpmsc_pkg.sv
// Purpose: constants for the loop mode and state controller
// Assumes: 32-bit APB, one word per register, 20 MHz pclk
// Notes:   all offsets are byte addresses
package dpmsc_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int MON_W     = 5;    // monitor kinds per reference
  localparam int PRIO_W    = 4;
  localparam int REF_IDX_W = 4;
  localparam int PRIO_PER_REG = 8;

  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_LOOP   = 8'h08;
  localparam logic [7:0] REG_LOCK   = 8'h0c;
  localparam logic [7:0] REG_PRIO0  = 8'h10;
  localparam logic [7:0] REG_PRIO1  = 8'h14;
  localparam logic [7:0] REG_OFFSET = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_HELD   = 8'h20;

  // ==========================================================
  // field positions
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_MODE_W     = 3;
  localparam int CTRL_REF_LSB    = 4;
  localparam int MASK_SW_LSB     = 0;
  localparam int MASK_RET_LSB    = 8;
  localparam int LOOP_BW_LSB     = 0;
  localparam int LOOP_BW_W       = 3;
  localparam int LOOP_DAMP_LSB   = 4;
  localparam int LOOP_DAMP_W     = 4;
  localparam int LOCK_PHASE_LSB  = 0;
  localparam int LOCK_PHASE_W    = 16;
  localparam int LOCK_PERIOD_LSB = 16;
  localparam int LOCK_PERIOD_W   = 8;
  localparam int LOCK_FAST_BIT   = 24;
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_REF_LSB    = 4;
  localparam int STAT_LOCK_BIT   = 8;
  localparam int STAT_RET_BIT    = 9;
  localparam int STAT_EXT_BIT    = 10;

  // ==========================================================
  // reset values and codes
  localparam logic [4:0]  MASK_RST        = 5'h1f;
  localparam logic [2:0]  BW_14HZ         = 3'h0;
  localparam logic [2:0]  BW_29HZ         = 3'h1;
  localparam logic [2:0]  BW_61HZ         = 3'h2;
  localparam logic [2:0]  BW_130HZ        = 3'h3;
  localparam logic [2:0]  BW_380HZ        = 3'h4;
  localparam logic [2:0]  BW_470HZ        = 3'h5;
  localparam logic [3:0]  DAMP_RST        = 4'h5;
  localparam logic [15:0] LOCK_PHASE_RST  = 16'h0100;
  localparam logic [7:0]  LOCK_PERIOD_RST = 8'h64;
  localparam logic [3:0]  PRIO_MAX        = 4'ha;
  localparam logic [3:0]  PRIO_OFF        = 4'hf;

  // ==========================================================
  // timing: lock period counts in milliseconds
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MODE_FREERUN, MODE_HOLDOVER, MODE_AUTO, MODE_FORCED, MODE_NCO
  } dpmsc_mode_t;

  typedef enum logic [1:0] {
    ST_FREE, ST_ACQ, ST_LOCK, ST_HOLD
  } dpmsc_state_t;

endpackage : dpmsc_pkg

// File: dpmsc_ref_src.sv
// Purpose: reference side model
// Assumes: all monitor kinds of a reference fail together
// Notes:   phase error stays inside the default lock window
`timescale 1ns/100ps
module dpmsc_ref_src #(
  parameter int NREF = 11
) (
  input  wire logic             pclk,             // clock
  input  wire logic             presetn,          // reset
  input  wire logic [NREF-1:0]  fail_cmd,         // references to fail
  output logic [NREF-1:0][4:0]  ref_monitor_fail, // monitor flags
  output logic [15:0]           phase_error_mag,  // phase error
  output logic [31:0]           loop_freq_word    // loop estimate
);
  // ==========================================================
  // estimate drifts every cycle so a frozen holdover word shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_error_mag  <= 16'hffff;
      loop_freq_word   <= 32'h1000_0000;
      ref_monitor_fail <= '0;
    end else begin
      phase_error_mag  <= 16'($urandom_range(0, 255));
      loop_freq_word   <= loop_freq_word + 32'($urandom_range(1, 15));
      for (int i = 0; i < NREF; i++) begin
        ref_monitor_fail[i] <= {5{fail_cmd[i]}};
      end
    end
  end
endmodule : dpmsc_ref_src

// File: tb_top.sv
// Purpose: self-checking bench for the loop controller
// Assumes: 20 MHz pclk, millisecond tick cut to four cycles
// Notes:   lock period is cut to two ticks to keep waits short
`timescale 1ns/100ps
module tb_top;
  import dpmsc_pkg::*;
  localparam int NREF = 11;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic                 lock_achieved_flag, retention_state_flag, dco_from_reference;
  logic                 fast_lock_enable, nco_update;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, dco_freq_word, loop_freq_word, rd;
  logic [NREF-1:0][4:0] ref_monitor_fail;
  logic [NREF-1:0]      fail_cmd;
  logic [15:0]          phase_error_mag;
  logic [3:0]           selected_reference, damping_gain;
  logic [2:0]           loop_bandwidth_select;
  logic [31:0]          mdl [9] = '{32'h0, 32'h1f1f, 32'h50, 32'h0064_0100, 32'h7654_3210,
                                    32'h0a98, 32'h0, 32'h0, 32'h0};
  int                   bad_count = 0;
  int                   cmp_count = 0;
  wire  [31:0]          flg = {29'h0, lock_achieved_flag, retention_state_flag, dco_from_reference};

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  dpmsc_ctrl #(.NREF(NREF), .TICK_CYCLES(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_monitor_fail(ref_monitor_fail), .phase_error_mag(phase_error_mag),
    .loop_freq_word(loop_freq_word), .lock_achieved_flag(lock_achieved_flag),
    .retention_state_flag(retention_state_flag), .selected_reference(selected_reference),
    .dco_from_reference(dco_from_reference), .dco_freq_word(dco_freq_word),
    .loop_bandwidth_select(loop_bandwidth_select), .damping_gain(damping_gain),
    .fast_lock_enable(fast_lock_enable), .nco_update(nco_update));

  dpmsc_ref_src #(.NREF(NREF)) u_src (.pclk(pclk), .presetn(presetn), .fail_cmd(fail_cmd),
    .ref_monitor_fail(ref_monitor_fail), .phase_error_mag(phase_error_mag),
    .loop_freq_word(loop_freq_word));

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : cyc

  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(n, 2);
    if (w && !err) mdl[a[5:2]] = d;
  endtask : apb

  task automatic mode(input logic [7:0] v);
    apb(1'b1, REG_CTRL, {24'h0, v});
  endtask : mode

  task automatic rdchk(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(rd, mdl[a[5:2]]);
  endtask : rdchk

  task automatic wait_flags(input logic [1:0] lh);
    int n = 0;
    do begin
      cyc(1);
      n++;
    end while (flg[2:1] !== lh && n < 400);
    chk({30'h0, flg[2:1]}, {30'h0, lh});
  endtask : wait_flags

  task automatic fail(input logic [NREF-1:0] f);
    @(posedge pclk);
    fail_cmd <= f;
  endtask : fail

  task automatic final_report;
    $display("cmp %0d, bad %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #(50 * 30000);
    bad_count++;
    final_report();
  end

  // ==========================================================
  // scenarios
  initial begin
    logic [3:0]  pr [NREF];
    logic [31:0] off;
    int          best;
    void'($urandom(32'h0211));
    {psel, penable, pwrite, presetn, paddr, pwdata, fail_cmd} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(8'(4 * i));
    apb(1'b0, 8'h24, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h28, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    for (int b = 0; b < 6; b++) begin
      off = $urandom();
      apb(1'b1, REG_LOOP, {24'h0, off[3:0], 1'b0, 3'(b)});
      cyc(1);
      chk({25'h0, damping_gain, loop_bandwidth_select}, {25'h0, off[3:0], 3'(b)});
    end
    rdchk(REG_LOOP);
    apb(1'b1, REG_LOCK, 32'h0102_0100);
    cyc(1);
    chk({31'h0, fast_lock_enable}, 32'h1);
    apb(1'b1, REG_LOCK, 32'h0002_0100);
    rdchk(REG_LOCK);
    fail('1);
    cyc(20);
    chk(flg | dco_freq_word, 32'h0);
    fail('0);
    mode(8'h02);
    wait_flags(2'b10);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h3f3, 32'h102);
    fail(11'h001);
    wait_flags(2'b01);
    wait_flags(2'b10);
    chk({28'h0, selected_reference}, 32'h1);
    mode(8'h01);
    wait_flags(2'b01);
    off = dco_freq_word;
    fail('1);
    cyc(30);
    chk(dco_freq_word, off);
    chk(flg, 32'h2);
    fail('0);
    mode(8'h02);
    wait_flags(2'b10);
    fail('1);
    wait_flags(2'b01);
    fail('0);
    mode(8'h00);
    mode(8'h33);
    wait_flags(2'b10);
    fail(11'h008);
    wait_flags(2'b01);
    cyc(20);
    chk({flg[1], 27'h0, selected_reference}, 32'h8000_0003);
    fail('0);
    wait_flags(2'b10);
    apb(1'b1, REG_MASK, 32'h001f);
    fail(11'h008);
    cyc(30);
    chk({flg[1:0], 26'h0, selected_reference}, 32'h4000_0003);
    mode(8'h00);
    apb(1'b1, REG_MASK, 32'h0);
    mode(8'h02);
    wait_flags(2'b10);
    fail(11'h009);
    cyc(30);
    chk({flg[1:0], 26'h0, selected_reference}, 32'h4000_0003);
    apb(1'b1, REG_MASK, 32'h1f00);
    wait_flags(2'b01);
    fail('0);
    apb(1'b1, REG_MASK, 32'h1f1f);
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < NREF; i++) begin
        pr[i] = 4'($urandom_range(0, 11));
        if (pr[i] == 4'hb) pr[i] = PRIO_OFF;
      end
      pr[10] = 4'($urandom_range(0, 10));
      best = NREF - 1;
      for (int i = NREF - 1; i >= 0; i--) if (pr[i] <= pr[best]) best = i;
      mode(8'h00);
      apb(1'b1, REG_PRIO0, {pr[7], pr[6], pr[5], pr[4], pr[3], pr[2], pr[1], pr[0]});
      apb(1'b1, REG_PRIO1, {20'h0, pr[10], pr[9], pr[8]});
      mode(8'h02);
      wait_flags(2'b10);
      chk({28'h0, selected_reference}, 32'(best));
    end
    mode(8'h04);
    repeat (2) begin
      off = $urandom();
      apb(1'b1, REG_OFFSET, off);
      #1 chk({31'h0, nco_update}, 32'h1);
    end
    cyc(2);
    chk(dco_freq_word, off);
    chk(flg, 32'h0);
    apb(1'b0, REG_OFFSET, 32'h0);
    chk(rd, 32'h0);
    for (int m = 5; m <= 8; m++) begin
      mode(8'(m % 8));
      cyc(3);
      chk(flg | dco_freq_word, 32'h0);
    end
    final_report();
  end
endmodule : tb_top
